// [rtl/mcs_top.v]
/*
 Counter with a serial register port: frame receive, CRC and address
 check, register reads and writes, replies, batching relays.
 Assumes counting pulses are one cycle long and synchronous to mclk.
*/
// Function
// - Characters are start, eight data, no parity.
// - Send two stop bits, accept one or two.
// - Bit rate selectable from 1200 to 115200.
// - Holding registers, signed values in two's complement.
// - Function 03h reads one or more registers.
// - Functions 06h and 10h write registers.
// - Broadcasts execute but never get replies.
// - Display value high at 01h, low at 02h.
// - Status 03h shows valid, overflow, underflow.
// - Batch start loads offset, energises both relays.
// - Subtraction mode: input B decrements counter.
// - Below first threshold, first relay drops.
// - Below second threshold, second relay drops.
// - Address 0 to 199; zero answers 255.
// - Optional reply delay of extra characters.
// - Config writes refused unless remote access on.
// - Watch time between frames; zero disables.
`timescale 1ns/100ps
`default_nettype none
`include "mcs_consts.vh"
module mcs_top #(
   parameter [25:0] CYC_PER_SEC = `CLK_HZ
) (
   // Clock and reset.
   input  wire        mclk,
   input  wire        nrst,
   // Serial line.
   input  wire        rs485_rx,
   output wire        rs485_tx,
   output wire        rs485_de,
   // Port settings.
   input  wire [7:0]  slave_addr,
   input  wire [2:0]  baud_sel,
   input  wire [2:0]  reply_delay_setting,
   input  wire        remote_config_access,
   input  wire [6:0]  frame_gap_timeout,
   // Counting and batching.
   input  wire        count_a,
   input  wire        count_b,
   input  wire        batch_start,
   input  wire [31:0] offset_value,
   input  wire [31:0] first_threshold,
   input  wire [31:0] second_threshold,
   // Results.
   output reg         first_relay,
   output reg         second_relay,
   output reg  [31:0] display_value,
   output reg         subtract_mode,
   output reg         frame_gap_alarm
);
   // ****************************************
   // States
   // ****************************************
   localparam [4:0] S_IDLE  = 5'h01;
   localparam [4:0] S_CHECK = 5'h02;
   localparam [4:0] S_EXEC  = 5'h04;
   localparam [4:0] S_WAIT  = 5'h08;
   localparam [4:0] S_SEND  = 5'h10;

   // ****************************************
   // Functions
   // ****************************************
   // Cycles per bit for each rate code.
   function [15:0] bit_div;
      input [2:0] s;
      begin
         case (s)
            3'h0: bit_div = `DIV_1200;
            3'h1: bit_div = `DIV_2400;
            3'h2: bit_div = `DIV_4800;
            3'h3: bit_div = `DIV_9600;
            3'h4: bit_div = `DIV_19200;
            3'h5: bit_div = `DIV_38400;
            3'h6: bit_div = `DIV_57600;
            default: bit_div = `DIV_115200;
         endcase
      end
   endfunction

   // Extra reply delay in characters for each setting.
   function [7:0] delay_chars;
      input [2:0] s;
      begin
         case (s)
            3'h1: delay_chars = 8'h0a;
            3'h2: delay_chars = 8'h14;
            3'h3: delay_chars = 8'h32;
            3'h4: delay_chars = 8'h64;
            3'h5: delay_chars = 8'hc8;
            default: delay_chars = 8'h00;
         endcase
      end
   endfunction

   // One byte step of the Modbus CRC, reflected polynomial.
   function [15:0] crc_step;
      input [15:0] c;
      input [7:0]  d;
      integer i;
      reg [15:0] r;
      begin
         r = c ^ {8'h00, d};
         for (i = 0; i < 8; i = i + 1)
            r = r[0] ? ({1'b0, r[15:1]} ^ 16'ha001) : {1'b0, r[15:1]};
         crc_step = r;
      end
   endfunction

   // ****************************************
   // Reset release
   // ****************************************
   reg  [1:0] rsync_q; // Two-stage release of the reset.
   wire       rst_n;   // Reset used by the rest of the design.

   always @(posedge mclk or negedge nrst) begin
      if (!nrst)
         rsync_q <= 2'b00;
      else
         rsync_q <= {rsync_q[0], 1'b1};
   end
   assign rst_n = rsync_q[1];

   // ****************************************
   // Serial ends
   // ****************************************
   wire [15:0] div_w = bit_div(baud_sel);
   wire [7:0]  rx_data;
   wire        rx_valid;
   wire        tx_busy;
   reg  [7:0]  tx_byte;  // Byte offered to the transmitter.
   reg  [7:0]  tx_data_q; // Byte latched together with the start pulse.
   reg         tx_go_q;  // Start pulse to the transmitter.

   mcs_rx u_rx (
      .clk     (mclk),
      .rst_n   (rst_n),
      .div     (div_w),
      .rx_in   (rs485_rx),
      .data_q  (rx_data),
      .valid_q (rx_valid)
   );

   mcs_tx u_tx (
      .clk    (mclk),
      .rst_n  (rst_n),
      .div    (div_w),
      .data   (tx_data_q),
      .start  (tx_go_q),
      .busy_q (tx_busy),
      .tx_q   (rs485_tx),
      .drive  (rs485_de)
   );

   // ****************************************
   // Frame state
   // ****************************************
   reg [7:0]  buf_q [0:`BUF_DEPTH-1]; // Received frame bytes.
   reg [6:0]  len_q;    // Bytes received.
   reg        ovf_q;    // Frame longer than the buffer.
   reg [15:0] crc_q;    // CRC over received bytes, zero when good.
   reg [22:0] gap_q;    // Silent cycles since the last byte.
   reg [4:0]  state_q;
   reg [4:0]  idx_q;    // Register index during writes.
   reg [6:0]  tx_idx_q; // Reply byte index.
   reg [15:0] txcrc_q;  // CRC over sent bytes.
   reg [26:0] dly_q;    // Reply delay cycles left.
   reg        frame_ok; // Valid frame seen this cycle.

   wire [7:0]  fc    = buf_q[1];
   wire [15:0] start = {buf_q[2], buf_q[3]};
   wire [15:0] qty   = {buf_q[4], buf_q[5]};
   wire        bcast = (buf_q[0] == 8'h00);
   // Address zero in the setting answers the alternate address.
   wire [7:0]  my_addr = (slave_addr == 8'h00) ? `ADDR_ZERO_ALT : slave_addr;
   // Gap of 3.5 characters: div times 11 times 7, halved.
   wire [22:0] gap_lim = (div_w * `CHAR_BITS * `GAP_HALFCH) >> 1;
   wire [26:0] dly_lim = div_w * `CHAR_BITS * delay_chars(reply_delay_setting);
   wire        grp_ok  = (qty != 16'h0000) && (qty <= `MAX_GROUP);
   wire [6:0]  rd_len  = 7'h05 + {1'b0, qty[4:0], 1'b0};
   wire [6:0]  tx_len  = (fc == `FC_READ) ? rd_len : 7'h08;

   // Request shape check per function code.
   reg fc_ok;
   always @* begin
      case (fc)
         `FC_READ:   fc_ok = (len_q == 7'h08) && grp_ok;
         `FC_WRITE1: fc_ok = (len_q == 7'h08);
         `FC_WRITEN: fc_ok = grp_ok && (buf_q[6] == {qty[6:0], 1'b0})
                             && (len_q == 7'h09 + {1'b0, qty[4:0], 1'b0});
         default:    fc_ok = 1'b0;
      endcase
   end

   // ****************************************
   // Register write strobe and read mux
   // ****************************************
   reg        wr_en;
   reg [15:0] wr_addr;
   reg [15:0] wr_data;
   always @* begin
      wr_en   = 1'b0;
      wr_addr = 16'h0000;
      wr_data = 16'h0000;
      if (state_q == S_EXEC) begin
         if (fc == `FC_WRITE1) begin
            wr_en   = 1'b1;
            wr_addr = start;
            wr_data = qty;
         end else if (fc == `FC_WRITEN) begin
            wr_en   = 1'b1;
            wr_addr = start + {11'h000, idx_q};
            wr_data = {buf_q[{idx_q, 1'b1} + 6'h06], buf_q[{idx_q, 1'b0} + 6'h08]};
         end
      end
   end

   wire [15:0] status_w; // Validity word of the display value.
   // Register contents; signed values appear in two's complement.
   function [15:0] reg_word;
      input [15:0] a;
      begin
         case (a)
            `REG_DISP_HI: reg_word = display_value[31:16];
            `REG_DISP_LO: reg_word = display_value[15:0];
            `REG_STATUS:  reg_word = status_w;
            `REG_RELAYS:  reg_word = {14'h0000, second_relay, first_relay};
            `REG_MODE:    reg_word = {15'h0000, subtract_mode};
            default:      reg_word = 16'h0000;
         endcase
      end
   endfunction

   // Reply byte for the current index.
   wire [6:0]  dat_i = tx_idx_q - 7'h03;
   wire [15:0] rd_w  = reg_word(start + {10'h000, dat_i[6:1]});
   always @* begin
      if (tx_idx_q == tx_len - 7'h02)
         tx_byte = txcrc_q[7:0];
      else if (tx_idx_q == tx_len - 7'h01)
         tx_byte = txcrc_q[15:8];
      else if (fc != `FC_READ || tx_idx_q < 7'h02)
         tx_byte = buf_q[tx_idx_q[5:0]];
      else if (tx_idx_q == 7'h02)
         tx_byte = {qty[6:0], 1'b0};
      else
         tx_byte = dat_i[0] ? rd_w[7:0] : rd_w[15:8];
   end

   // ****************************************
   // Frame sequencer
   // ****************************************
   // Bytes arriving outside the idle state are dropped; a master must
   // not talk over a reply anyway.
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_q  <= S_IDLE;
         len_q    <= 7'h00;
         ovf_q    <= 1'b0;
         crc_q    <= 16'hffff;
         gap_q    <= 23'h000000;
         idx_q    <= 5'h00;
         tx_idx_q <= 7'h00;
         txcrc_q  <= 16'hffff;
         dly_q    <= 27'h0000000;
         tx_data_q <= 8'h00;
         tx_go_q  <= 1'b0;
         frame_ok <= 1'b0;
      end else begin
         tx_go_q  <= 1'b0;
         frame_ok <= 1'b0;
         case (state_q)
            S_IDLE: begin
               if (rx_valid) begin
                  if (len_q == `BUF_DEPTH)
                     ovf_q <= 1'b1;
                  else begin
                     buf_q[len_q[5:0]] <= rx_data;
                     len_q <= len_q + 7'h01;
                  end
                  crc_q <= crc_step(crc_q, rx_data);
                  gap_q <= 23'h000000;
               end else if (len_q != 7'h00) begin
                  gap_q <= gap_q + 23'h000001;
                  if (gap_q >= gap_lim)
                     state_q <= S_CHECK;
               end
            end
            S_CHECK: begin
               idx_q    <= 5'h00;
               tx_idx_q <= 7'h00;
               txcrc_q  <= 16'hffff;
               dly_q    <= dly_lim;
               // Bad CRC or another address: drop without a word.
               if (!ovf_q && crc_q == 16'h0000 && fc_ok
                   && (bcast || buf_q[0] == my_addr)) begin
                  state_q  <= S_EXEC;
                  frame_ok <= 1'b1;
               end else begin
                  state_q <= S_IDLE;
                  len_q   <= 7'h00;
                  ovf_q   <= 1'b0;
                  crc_q   <= 16'hffff;
               end
            end
            S_EXEC: begin
               idx_q <= idx_q + 5'h01;
               if (fc != `FC_WRITEN || idx_q == qty[4:0] - 5'h01) begin
                  // Broadcasts are carried out but never answered.
                  if (bcast) begin
                     state_q <= S_IDLE;
                     len_q   <= 7'h00;
                     crc_q   <= 16'hffff;
                  end else
                     state_q <= S_WAIT;
               end
            end
            S_WAIT: begin
               // The end gap already gave the minimum turnaround.
               if (dly_q == 27'h0000000)
                  state_q <= S_SEND;
               else
                  dly_q <= dly_q - 27'h0000001;
            end
            S_SEND: begin
               if (!tx_busy && !tx_go_q) begin
                  if (tx_idx_q == tx_len) begin
                     state_q <= S_IDLE;
                     len_q   <= 7'h00;
                     crc_q   <= 16'hffff;
                  end else begin
                     tx_go_q   <= 1'b1;
                     tx_data_q <= tx_byte;
                     // The check word is sent as it stood before its first byte.
                     if (tx_idx_q < tx_len - 7'h02)
                        txcrc_q <= crc_step(txcrc_q, tx_byte);
                     tx_idx_q <= tx_idx_q + 7'h01;
                  end
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // ****************************************
   // Counter, relays and mode
   // ****************************************
   assign status_w = ($signed(display_value) > $signed(`DISP_MAX)) ? `ST_OVER :
                     ($signed(display_value) < $signed(`DISP_MIN)) ? `ST_UNDER :
                     `ST_VALID;

   wire [31:0] step_b = (subtract_mode && count_b) ? 32'hffffffff :
                        {31'h00000000, count_b};
   wire [31:0] next_v = display_value + {31'h00000000, count_a} + step_b;

   // Batch start has priority, then serial writes, then thresholds.
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         display_value <= 32'h00000000;
         first_relay   <= 1'b0;
         second_relay  <= 1'b0;
         subtract_mode <= 1'b0;
      end else begin
         display_value <= next_v;
         if (batch_start) begin
            display_value <= offset_value;
            first_relay   <= 1'b1;
            second_relay  <= 1'b1;
         end else if (wr_en && wr_addr == `REG_RELAYS) begin
            // Relay state stays writable whatever the access setting.
            first_relay  <= wr_data[0];
            second_relay <= wr_data[1];
         end else begin
            if ($signed(display_value) < $signed(first_threshold))
               first_relay <= 1'b0;
            if ($signed(display_value) < $signed(second_threshold))
               second_relay <= 1'b0;
         end
         // Configuration writes take effect only with remote access on.
         if (wr_en && wr_addr == `REG_MODE && remote_config_access)
            subtract_mode <= wr_data[0];
      end
   end

   // ****************************************
   // Frame interval watch
   // ****************************************
   reg [25:0] sec_cyc_q; // Cycles within the current second.
   reg [6:0]  secs_q;    // Whole seconds since the last good frame.
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sec_cyc_q       <= 26'h0000000;
         secs_q          <= 7'h00;
         frame_gap_alarm <= 1'b0;
      end else begin
         if (frame_ok) begin
            sec_cyc_q <= 26'h0000000;
            secs_q    <= 7'h00;
         end else if (sec_cyc_q == CYC_PER_SEC - 26'h0000001) begin
            sec_cyc_q <= 26'h0000000;
            if (secs_q != 7'h7f)
               secs_q <= secs_q + 7'h01;
         end else
            sec_cyc_q <= sec_cyc_q + 26'h0000001;
         // A zero setting switches the watch off.
         frame_gap_alarm <= (frame_gap_timeout != 7'h00)
                            && (secs_q >= frame_gap_timeout);
      end
   end
endmodule // mcs_top
`default_nettype wire

// [include/mcs_consts.vh]
/*
 Constants for the counter's serial register port: register numbers,
 function codes, status words, display limits and framing counts.
 Assumes inclusion by bare name from the rtl files.
*/
`ifndef MCS_CONSTS_VH
`define MCS_CONSTS_VH
// Register numbers.
`define REG_DISP_HI   16'h0001
`define REG_DISP_LO   16'h0002
`define REG_STATUS    16'h0003
`define REG_RELAYS    16'h0008
`define REG_MODE      16'h0015
// First register number that counts as configuration.
`define REG_CFG_FIRST 16'h0010
// Function codes.
`define FC_READ       8'h03
`define FC_WRITE1     8'h06
`define FC_WRITEN     8'h10
// Status words of the display value.
`define ST_VALID      16'h0000
`define ST_OVER       16'h0080
`define ST_UNDER      16'h0040
// Display range, 999999 and -99999.
`define DISP_MAX      32'h000f423f
`define DISP_MIN      32'hfffe7961
// Largest register group in one frame.
`define MAX_GROUP     16'h0010
// Slave address answered when the address setting is zero.
`define ADDR_ZERO_ALT 8'hff
// Bit times in one character and half characters in the end gap.
`define CHAR_BITS     8'h0b
`define GAP_HALFCH    8'h07
// Clock 50 MHz and cycles per bit for each rate.
`define CLK_HZ        26'h2faf080
`define DIV_1200      16'ha2c3
`define DIV_2400      16'h5161
`define DIV_4800      16'h28b1
`define DIV_9600      16'h1458
`define DIV_19200     16'h0a2c
`define DIV_38400     16'h0516
`define DIV_57600     16'h0364
`define DIV_115200    16'h01b2
// Receive buffer depth.
`define BUF_DEPTH     64
`endif

// [rtl/mcs_uart_rx.v]
/*
 Serial receiver: one start bit, eight data bits, no parity.
 Assumes rx input synchronous to clk and div the cycles per bit.
*/
`timescale 1ns/100ps
`default_nettype none
module mcs_rx (
   // Clock and reset.
   input  wire        clk,
   input  wire        rst_n,
   // Configuration.
   input  wire [15:0] div,
   // Line.
   input  wire        rx_in,
   // Received byte.
   output reg  [7:0]  data_q,
   output reg         valid_q
);
   reg        busy_q;   // A character is in progress.
   reg [15:0] cnt_q;    // Cycles to the next sample point.
   reg [3:0]  bit_q;    // Bit position, 0 start to 9 stop.

   // ****************************************
   // Sampling at mid bit
   // ****************************************
   // Only the first stop bit is checked, so one or two stop bits pass.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_q  <= 1'b0;
         cnt_q   <= 16'h0000;
         bit_q   <= 4'h0;
         data_q  <= 8'h00;
         valid_q <= 1'b0;
      end else begin
         valid_q <= 1'b0;
         if (!busy_q) begin
            // A falling line starts a character.
            if (!rx_in) begin
               busy_q <= 1'b1;
               cnt_q  <= {1'b0, div[15:1]};
               bit_q  <= 4'h0;
            end
         end else if (cnt_q != 16'h0000) begin
            cnt_q <= cnt_q - 16'h0001;
         end else begin
            cnt_q <= div - 16'h0001;
            bit_q <= bit_q + 4'h1;
            if (bit_q == 4'h0) begin
               // A glitch that is high again at mid start is dropped.
               if (rx_in)
                  busy_q <= 1'b0;
            end else if (bit_q < 4'h9) begin
               data_q <= {rx_in, data_q[7:1]};
            end else begin
               busy_q  <= 1'b0;
               valid_q <= rx_in;
            end
         end
      end
   end
endmodule // mcs_rx
`default_nettype wire

// [rtl/mcs_uart_tx.v]
/*
 Serial transmitter: start bit, eight data bits, two stop bits.
 Assumes start is a one-cycle pulse given only while busy is low.
*/
`timescale 1ns/100ps
`default_nettype none
module mcs_tx (
   // Clock and reset.
   input  wire        clk,
   input  wire        rst_n,
   // Configuration.
   input  wire [15:0] div,
   // Byte to send.
   input  wire [7:0]  data,
   input  wire        start,
   output reg         busy_q,
   // Line and driver enable.
   output reg         tx_q,
   output wire        drive
);
   reg [10:0] sh_q;   // Bits still to send, lsb first.
   reg [3:0]  left_q; // Bits remaining.
   reg [15:0] cnt_q;  // Cycles left in the current bit.

   // The driver stays on across the whole character.
   assign drive = busy_q;

   // ****************************************
   // Shift out
   // ****************************************
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_q <= 1'b0;
         tx_q   <= 1'b1;
         sh_q   <= 11'h7ff;
         left_q <= 4'h0;
         cnt_q  <= 16'h0000;
      end else if (!busy_q) begin
         tx_q <= 1'b1;
         if (start) begin
            // Two stop bits on every character.
            sh_q   <= {2'b11, data, 1'b0};
            left_q <= 4'hb;
            cnt_q  <= 16'h0000;
            busy_q <= 1'b1;
         end
      end else if (cnt_q != 16'h0000) begin
         cnt_q <= cnt_q - 16'h0001;
      end else if (left_q == 4'h0) begin
         busy_q <= 1'b0;
      end else begin
         tx_q   <= sh_q[0];
         sh_q   <= {1'b1, sh_q[10:1]};
         left_q <= left_q - 4'h1;
         cnt_q  <= div - 16'h0001;
      end
   end
endmodule // mcs_tx
`default_nettype wire

// [verification/mcs_master.sv]
/*
 Serial master model for the counter port: sends framed requests and
 receives reply characters. Assumes 50 MHz mclk and 115200 bit/s.
*/
`timescale 1ns/100ps
`default_nettype none
module mcs_master (
   // Clock and line.
   input  wire logic mclk,
   input  wire logic line_in,
   output var  logic line_out
);
   localparam int BIT = 434; // Cycles per bit at the fastest rate.
   logic [15:0] crc_q;       // Running frame check of sent bytes.
   initial line_out = 1'b1;
   // Frame check step; reflected polynomial 0xa001, seed 0xffff.
   function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] d);
      c = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
      return c;
   endfunction
   // One character, low bit first, one stop bit to save line time.
   task automatic put(input logic [7:0] b);
      for (int i = 0; i < 10; i++) begin
         line_out <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
         repeat (BIT) @(posedge mclk);
      end
      crc_q = crc16(crc_q, b);
   endtask
   // Six bytes, then the check word low byte first.
   task automatic send6(input logic [47:0] f);
      logic [15:0] c;
      crc_q = 16'hffff;
      for (int i = 5; i >= 0; i--) put(f[i*8 +: 8]);
      c = crc_q;
      put(c[7:0]);
      put(c[15:8]);
   endtask
   // One reply character; ok is low on no start or a bad stop bit.
   task automatic get(output logic [7:0] b, output logic ok);
      int n;
      n = 0;
      while (line_in !== 1'b0 && n < 30000) begin
         @(posedge mclk);
         n++;
      end
      repeat (BIT / 2) @(posedge mclk);
      for (int i = 0; i < 9; i++) begin
         repeat (BIT) @(posedge mclk);
         if (i < 8) b[i] = line_in;
      end
      ok = (n < 30000) && (line_in === 1'b1);
   endtask
endmodule // mcs_master
`default_nettype wire

// [verification/mcs_top_props.sv]
/*
 Checker for the counter port: line framing, batching and counting.
 Assumes binding to mcs_top; it sees only that module's ports.
*/
`timescale 1ns/100ps
`default_nettype none
module mcs_top_props #(
   parameter [25:0] CYC_PER_SEC = 26'h2faf080
) (
   // Clock, reset and serial line.
   input wire logic mclk,
   input wire logic nrst,
   input wire logic rs485_rx,
   input wire logic rs485_tx,
   input wire logic rs485_de,
   // Port settings.
   input wire logic [7:0] slave_addr,
   input wire logic [2:0] baud_sel,
   input wire logic [2:0] reply_delay_setting,
   input wire logic remote_config_access,
   input wire logic [6:0] frame_gap_timeout,
   // Counting and results.
   input wire logic count_a,
   input wire logic count_b,
   input wire logic batch_start,
   input wire logic [31:0] offset_value,
   input wire logic [31:0] first_threshold,
   input wire logic [31:0] second_threshold,
   input wire logic first_relay,
   input wire logic second_relay,
   input wire logic [31:0] display_value,
   input wire logic subtract_mode,
   input wire logic frame_gap_alarm
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   logic [15:0] hi_run_q; // Cycles the line has stayed high, saturating.
   // Run length lets the stop-bit check span many bit times cheaply.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst || !rs485_tx) hi_run_q <= 16'h0000;
      else if (hi_run_q != 16'hffff) hi_run_q <= hi_run_q + 16'h0001;
   end
   idle_line_a: assert property (!rs485_de |-> rs485_tx)
      else $error("line low while driver off");
   two_stops_a: assert property ($fell(rs485_de) && baud_sel == 3'h7 |-> hi_run_q > 16'h035c)
      else $error("character ended with under two stop bits");
   batch_load_a: assert property (batch_start |=> first_relay && second_relay
      && display_value == $past(offset_value))
      else $error("batch start did not load and energise");
   first_drop_a: assert property (first_relay && !batch_start
      && $signed(display_value) < $signed(first_threshold) |=> !first_relay)
      else $error("first relay held below threshold");
   second_drop_a: assert property (second_relay && !batch_start
      && $signed(display_value) < $signed(second_threshold) |=> !second_relay)
      else $error("second relay held below threshold");
   sub_step_a: assert property (subtract_mode && count_b && !count_a && !batch_start
      |=> display_value == $past(display_value) - 32'h00000001)
      else $error("subtract pulse did not decrement");
   add_step_a: assert property (!subtract_mode && count_a && !count_b && !batch_start
      |=> display_value == $past(display_value) + 32'h00000001)
      else $error("input a pulse did not increment");
   value_hold_a: assert property (!count_a && !count_b && !batch_start
      |=> $stable(display_value))
      else $error("value moved without a pulse");
endmodule // mcs_top_props
bind mcs_top mcs_top_props #(.CYC_PER_SEC(CYC_PER_SEC)) chk (.mclk, .nrst, .rs485_rx,
   .rs485_tx, .rs485_de, .slave_addr, .baud_sel, .reply_delay_setting,
   .remote_config_access, .frame_gap_timeout, .count_a, .count_b, .batch_start,
   .offset_value, .first_threshold, .second_threshold, .first_relay, .second_relay,
   .display_value, .subtract_mode, .frame_gap_alarm);
`default_nettype wire

// [verification/mcs_top_bench.sv]
/*
 Testbench for the counter port: batching, counting, broadcast write
 and a register read. Assumes the master model and checker beside it.
*/
`timescale 1ns/100ps
`default_nettype none
module mcs_top_bench;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic count_a = 1'b0;
   logic count_b = 1'b0;
   logic batch_start = 1'b0;
   logic [31:0] offset_value = 32'h0000000a, first_threshold = 32'h0000000a;
   logic [31:0] second_threshold = 32'h00000000;
   logic [6:0] frame_gap_timeout = 7'h01;
   wire logic rs485_rx, rs485_tx, rs485_de, first_relay, second_relay;
   wire logic subtract_mode, frame_gap_alarm;
   wire logic [31:0] display_value;
   wire logic rx_line = rs485_de ? rs485_tx : 1'b1; // Bias pulls an idle bus high.
   int error_cnt = 0, tests_run = 0, cyc = 0;
   always #10 mclk = ~mclk;
   mcs_top #(.CYC_PER_SEC(26'h0003e8)) dut (.mclk, .nrst, .rs485_rx, .rs485_tx,
      .rs485_de, .slave_addr(8'h01), .baud_sel(3'h7), .reply_delay_setting(3'h0),
      .remote_config_access(1'b1), .frame_gap_timeout, .count_a, .count_b,
      .batch_start, .offset_value, .first_threshold, .second_threshold, .first_relay,
      .second_relay, .display_value, .subtract_mode, .frame_gap_alarm);
   mcs_master m (.mclk, .line_in(rx_line), .line_out(rs485_rx));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic summarize();
      if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Pulses {batch, a, b} k times, each one cycle wide.
   task automatic pulse(input logic [2:0] s, input int k);
      repeat (k) begin
         @(posedge mclk);
         {batch_start, count_a, count_b} <= s;
         @(posedge mclk);
         {batch_start, count_a, count_b} <= 3'h0;
      end
      repeat (2) @(posedge mclk);
   endtask
   // A hang counts as a mismatch.
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 200000) begin
         error_cnt++;
         summarize();
      end
   end
   initial begin
      logic [7:0] b;
      logic ok;
      logic [15:0] c;
      logic [55:0] exp;
      int n;
      repeat (20) @(posedge mclk);
      nrst <= 1'b1;
      repeat (1200) @(posedge mclk);
      chk("alarm", 32'h1, frame_gap_alarm);
      frame_gap_timeout <= 7'h00;
      pulse(3'h4, 1);
      chk("alarm off", 32'h0, frame_gap_alarm);
      chk("relays", 32'h3, {first_relay, second_relay});
      chk("value", 32'ha, display_value);
      first_threshold <= 32'h0000000b;
      pulse(3'h2, 1);
      chk("first relay", 32'h0, first_relay);
      chk("value", 32'hb, display_value);
      m.send6(48'h000600150001);
      n = 0;
      repeat (18000) @(posedge mclk) n += int'(rs485_de);
      chk("reply cycles", 32'h0, n);
      chk("mode", 32'h1, subtract_mode);
      {offset_value, first_threshold, second_threshold} <= {32'hb, 32'h8, 32'h5};
      pulse(3'h4, 1);
      pulse(3'h1, 3);
      chk("first relay", 32'h1, first_relay);
      pulse(3'h1, 1);
      chk("relays", 32'h1, {first_relay, second_relay});
      pulse(3'h1, 3);
      chk("relays", 32'h0, {first_relay, second_relay});
      chk("value", 32'h4, display_value);
      m.send6(48'h010300020002);
      exp = 56'h01030400040000;
      c = 16'hffff;
      for (int i = 0; i < 9; i++) begin
         m.get(b, ok);
         chk("stop bit", 32'h1, ok);
         if (i < 7) chk("reply", exp[(6-i)*8 +: 8], b);
         else chk("check", (i == 7) ? c[7:0] : c[15:8], b);
         if (i < 7) c = m.crc16(c, exp[(6-i)*8 +: 8]);
      end
      summarize();
   end
endmodule // mcs_top_bench
`default_nettype wire
